// ===== slpid_pkg.sv
package slpid_pkg;

  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned TICK_MS         = 100;
  localparam int unsigned TICK_CYCLES_DEF = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned TICK_W          = 20;
  localparam int unsigned CYC_BASE_MS     = 500;
  localparam logic [15:0] CYC_BASE_TICKS  = 16'(CYC_BASE_MS / TICK_MS);
  localparam logic [15:0] LISTEN_TICKS_DEF = 16'h0001;

  localparam logic [7:0]  CMD_SLEEP_SELECT  = 8'h01;
  localparam logic [7:0]  CMD_IDLE_TIME     = 8'h02;
  localparam logic [7:0]  CMD_SERIAL_UPPER  = 8'h25;
  localparam logic [7:0]  CMD_SERIAL_LOWER  = 8'h26;

  localparam logic [7:0]  SEL_NONE      = 8'h00;
  localparam logic [7:0]  SEL_PIN       = 8'h01;
  localparam logic [7:0]  SEL_CYC_FIRST = 8'h03;
  localparam logic [7:0]  SEL_CYC_LAST  = 8'h08;
  localparam logic [7:0]  SEL_RESET     = SEL_NONE;

  localparam logic [15:0] IDLE_MIN   = 16'h0010;
  localparam logic [15:0] IDLE_RESET = 16'h0064;

  localparam logic [1:0]  BYTES_NONE = 2'h0;
  localparam logic [1:0]  BYTES_ONE  = 2'h1;
  localparam logic [1:0]  BYTES_TWO  = 2'h2;

  // Arbitrary serial number; replace per unit.
  localparam logic [31:0] SERIAL_DEF = 32'h0000_0001;

  typedef struct packed {
    logic        write;
    logic [7:0]  code;
    logic [15:0] wdata;
  } slpid_cmd_t;

  typedef struct packed {
    logic        ok;
    logic [1:0]  bytes;
    logic [15:0] data;
  } slpid_rsp_t;

  typedef enum logic [2:0] {
    PWR_AWAKE,
    PWR_PIN_SLEEP,
    PWR_CYC_SLEEP,
    PWR_LISTEN,
    PWR_SYNC
  } slpid_state_t;

endpackage

// ===== slpid_top.sv
// Notes on behaviour
// - Command 0x25 reads the upper sixteen bits of the serial number as two bytes.
// - Command 0x26 reads the lower sixteen bits of the serial number as two bytes.
// - The selector means awake for 0, pin sleep for 1 and cyclic 0.5 to 16 s for 3 to 8.
// - The selector is 0 after reset so the module stays awake.
// - In a cyclic setting the module wakes each time the chosen period has run out.
// - A preamble seen while awake in cyclic sleep is followed, and data is taken after it ends.
// - With no preamble in the listen window the module sleeps again and keeps cycling.
// - Command 0x02 sets the idle time in 100 ms steps, accepts 0x10 to 0xffff, returns two bytes.
// - The idle time is 0x64 after reset, ten seconds.
// - Cyclic sleep follows only a full idle time without traffic, and traffic restarts it.
// - The idle timer only acts in a cyclic setting.
`timescale 1ns/10ps
`default_nettype none
module slpid_top #(
  parameter int unsigned TICK_CYCLES  = slpid_pkg::TICK_CYCLES_DEF,
  parameter logic [15:0] LISTEN_TICKS = slpid_pkg::LISTEN_TICKS_DEF,
  parameter logic [31:0] SERIAL_NUM   = slpid_pkg::SERIAL_DEF
) (
  input  wire logic             mclk,
  input  wire logic             sys_rst,
  input  wire logic             cmd_valid,
  input  wire slpid_pkg::slpid_cmd_t cmd,
  input  wire logic             tx_active,
  input  wire logic             rx_active,
  input  wire logic             preamble_detect,
  input  wire logic             preamble_done,
  input  wire logic             sleep_pin,
  output logic                  rsp_valid,
  output slpid_pkg::slpid_rsp_t rsp,
  output logic                  module_asleep,
  output logic                  rx_enable
);
  import slpid_pkg::*;

  function automatic logic is_cyclic(input logic [7:0] sel);
    is_cyclic = (sel >= SEL_CYC_FIRST) && (sel <= SEL_CYC_LAST);
  endfunction

  function automatic logic [15:0] period_ticks(input logic [7:0] sel);
    logic [7:0] shift;
    shift = sel - SEL_CYC_FIRST;
    period_ticks = CYC_BASE_TICKS << shift[2:0];
  endfunction

  logic [7:0]   sleep_select_reg;
  logic [7:0]   sleep_select_next;
  logic [15:0]  idle_time_reg;
  logic [15:0]  idle_time_next;
  logic         rsp_valid_reg;
  logic         rsp_valid_next;
  slpid_rsp_t   rsp_reg;
  slpid_rsp_t   rsp_next;
  logic         sel_wr;

  always_comb begin
    sleep_select_next = sleep_select_reg;
    idle_time_next    = idle_time_reg;
    rsp_valid_next    = cmd_valid;
    rsp_next          = '0;
    sel_wr            = 1'b0;
    if (cmd_valid) begin
      case (cmd.code)
        CMD_SERIAL_UPPER: begin
          rsp_next.data  = SERIAL_NUM[31:16];
          rsp_next.bytes = BYTES_TWO;
          rsp_next.ok    = !cmd.write;
        end
        CMD_SERIAL_LOWER: begin
          rsp_next.data  = SERIAL_NUM[15:0];
          rsp_next.bytes = BYTES_TWO;
          rsp_next.ok    = !cmd.write;
        end
        CMD_SLEEP_SELECT: begin
          rsp_next.bytes = BYTES_ONE;
          rsp_next.ok    = 1'b1;
          rsp_next.data  = {8'h00, sleep_select_reg};
          if (cmd.write) begin
            if (cmd.wdata[15:8] == 8'h00 && (cmd.wdata[7:0] == SEL_NONE ||
                cmd.wdata[7:0] == SEL_PIN || is_cyclic(cmd.wdata[7:0]))) begin
              sleep_select_next = cmd.wdata[7:0];
              sel_wr            = 1'b1;
              rsp_next.data     = cmd.wdata;
            end else begin
              rsp_next.ok = 1'b0;
            end
          end
        end
        CMD_IDLE_TIME: begin
          rsp_next.bytes = BYTES_TWO;
          rsp_next.ok    = 1'b1;
          rsp_next.data  = idle_time_reg;
          if (cmd.write) begin
            if (cmd.wdata >= IDLE_MIN) begin
              idle_time_next = cmd.wdata;
              rsp_next.data  = cmd.wdata;
            end else begin
              rsp_next.ok = 1'b0;
            end
          end
        end
        default: begin
          rsp_next.ok    = 1'b0;
          rsp_next.bytes = BYTES_NONE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sleep_select_reg <= SEL_RESET;
      idle_time_reg    <= IDLE_RESET;
      rsp_valid_reg    <= 1'b0;
      rsp_reg          <= '0;
    end else begin
      sleep_select_reg <= sleep_select_next;
      idle_time_reg    <= idle_time_next;
      rsp_valid_reg    <= rsp_valid_next;
      rsp_reg          <= rsp_next;
    end
  end

  // The sleep pin is asynchronous, so it passes two flip-flops first.
  logic pin_meta_reg;
  logic pin_sync_reg;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pin_meta_reg <= 1'b0;
      pin_sync_reg <= 1'b0;
    end else begin
      pin_meta_reg <= sleep_pin;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  slpid_state_t      state_reg;
  slpid_state_t      state_next;
  logic [TICK_W-1:0] tick_cnt_reg;
  logic [TICK_W-1:0] tick_cnt_next;
  logic [15:0]       unit_cnt_reg;
  logic [15:0]       unit_cnt_next;
  logic              asleep_reg;
  logic              asleep_next;
  logic              rx_en_reg;
  logic              rx_en_next;
  logic              clr;
  logic              activity;

  assign activity = tx_active || rx_active;

  always_comb begin
    state_next = state_reg;
    clr        = 1'b0;
    if (sel_wr) begin
      state_next = PWR_AWAKE;
      clr        = 1'b1;
    end else begin
      case (state_reg)
        PWR_AWAKE: begin
          if (activity) begin
            clr = 1'b1;
          end else if (sleep_select_reg == SEL_PIN && pin_sync_reg) begin
            state_next = PWR_PIN_SLEEP;
          end else if (is_cyclic(sleep_select_reg) &&
                       unit_cnt_reg >= idle_time_reg) begin
            state_next = PWR_CYC_SLEEP;
            clr        = 1'b1;
          end
        end
        PWR_PIN_SLEEP: begin
          if (!pin_sync_reg) begin
            state_next = PWR_AWAKE;
            clr        = 1'b1;
          end
        end
        PWR_CYC_SLEEP: begin
          if (unit_cnt_reg >= period_ticks(sleep_select_reg)) begin
            state_next = PWR_LISTEN;
            clr        = 1'b1;
          end
        end
        PWR_LISTEN: begin
          if (preamble_detect) begin
            state_next = PWR_SYNC;
          end else if (unit_cnt_reg >= LISTEN_TICKS) begin
            state_next = PWR_CYC_SLEEP;
            clr        = 1'b1;
          end
        end
        PWR_SYNC: begin
          if (preamble_done) begin
            state_next = PWR_AWAKE;
            clr        = 1'b1;
          end
        end
        default: begin
          state_next = PWR_AWAKE;
          clr        = 1'b1;
        end
      endcase
    end
    asleep_next = (state_next == PWR_PIN_SLEEP) || (state_next == PWR_CYC_SLEEP);
    rx_en_next  = (state_next == PWR_AWAKE);
  end

  // The prescaler restarts with every interval, so each one is a whole number of ticks.
  always_comb begin
    tick_cnt_next = tick_cnt_reg + 1'b1;
    unit_cnt_next = unit_cnt_reg;
    if (clr) begin
      tick_cnt_next = '0;
      unit_cnt_next = '0;
    end else if (tick_cnt_reg == TICK_W'(TICK_CYCLES - 1)) begin
      tick_cnt_next = '0;
      if (unit_cnt_reg != 16'hffff) begin
        unit_cnt_next = unit_cnt_reg + 16'h0001;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_reg    <= PWR_AWAKE;
      tick_cnt_reg <= '0;
      unit_cnt_reg <= '0;
      asleep_reg   <= 1'b0;
      rx_en_reg    <= 1'b1;
    end else begin
      state_reg    <= state_next;
      tick_cnt_reg <= tick_cnt_next;
      unit_cnt_reg <= unit_cnt_next;
      asleep_reg   <= asleep_next;
      rx_en_reg    <= rx_en_next;
    end
  end

  assign rsp_valid     = rsp_valid_reg;
  assign rsp           = rsp_reg;
  assign module_asleep = asleep_reg;
  assign rx_enable     = rx_en_reg;

  logic rd_cmd;
  logic wr_cmd;
  assign rd_cmd = cmd_valid && !cmd.write;
  assign wr_cmd = cmd_valid && cmd.write;

  AST_SER_UPPER: assert property (@(posedge mclk) disable iff (sys_rst)
    rd_cmd && cmd.code == CMD_SERIAL_UPPER |=> rsp_valid && rsp.ok &&
    rsp.data == SERIAL_NUM[31:16] && rsp.bytes == BYTES_TWO)
    else $error("serial upper read wrong");
  AST_SER_LOWER: assert property (@(posedge mclk) disable iff (sys_rst)
    rd_cmd && cmd.code == CMD_SERIAL_LOWER |=> rsp_valid && rsp.ok &&
    rsp.data == SERIAL_NUM[15:0] && rsp.bytes == BYTES_TWO)
    else $error("serial lower read wrong");
  AST_SEL_BAD: assert property (@(posedge mclk) disable iff (sys_rst)
    wr_cmd && cmd.code == CMD_SLEEP_SELECT && cmd.wdata == 16'h0002
    |=> !rsp.ok && $stable(sleep_select_reg))
    else $error("illegal sleep selector accepted");
  AST_SEL_RESET: assert property (@(posedge mclk)
    sys_rst |=> sleep_select_reg == SEL_NONE && !module_asleep)
    else $error("selector not cleared by reset");
  AST_CYC_WAKE: assert property (@(posedge mclk) disable iff (sys_rst)
    state_reg == PWR_CYC_SLEEP && !sel_wr &&
    unit_cnt_reg >= period_ticks(sleep_select_reg)
    |=> state_reg == PWR_LISTEN && !module_asleep && unit_cnt_reg == 16'h0000)
    else $error("cyclic wake missed");
  AST_SYNC: assert property (@(posedge mclk) disable iff (sys_rst)
    state_reg == PWR_LISTEN && preamble_detect && !sel_wr
    |=> state_reg == PWR_SYNC && !rx_enable)
    else $error("preamble not followed");
  AST_SYNC_DONE: assert property (@(posedge mclk) disable iff (sys_rst)
    state_reg == PWR_SYNC && preamble_done |=> rx_enable && !module_asleep)
    else $error("data not accepted after preamble");
  AST_NO_PREAMBLE: assert property (@(posedge mclk) disable iff (sys_rst)
    state_reg == PWR_LISTEN && !preamble_detect && !sel_wr &&
    unit_cnt_reg >= LISTEN_TICKS |=> module_asleep && state_reg == PWR_CYC_SLEEP)
    else $error("no return to sleep after empty window");
  AST_IDLE_MIN: assert property (@(posedge mclk) disable iff (sys_rst)
    wr_cmd && cmd.code == CMD_IDLE_TIME && cmd.wdata < IDLE_MIN
    |=> $stable(idle_time_reg) && !rsp.ok && rsp.bytes == BYTES_TWO)
    else $error("short idle time accepted");
  AST_IDLE_RESET: assert property (@(posedge mclk)
    sys_rst |=> idle_time_reg == IDLE_RESET)
    else $error("idle time reset value wrong");
  AST_ACTIVITY: assert property (@(posedge mclk) disable iff (sys_rst)
    state_reg == PWR_AWAKE && activity |=> state_reg == PWR_AWAKE &&
    unit_cnt_reg == 16'h0000)
    else $error("traffic did not restart idle time");
  AST_NONCYC: assert property (@(posedge mclk) disable iff (sys_rst)
    !is_cyclic(sleep_select_reg) |-> state_reg != PWR_CYC_SLEEP &&
    state_reg != PWR_LISTEN && state_reg != PWR_SYNC)
    else $error("idle timer acted outside cyclic setting");
  AST_SER_WRITE: assert property (@(posedge mclk) disable iff (sys_rst)
    wr_cmd && (cmd.code == CMD_SERIAL_UPPER || cmd.code == CMD_SERIAL_LOWER)
    |=> rsp_valid && !rsp.ok)
    else $error("serial word write accepted");

  COV_CYC_SLEEP: cover property (@(posedge mclk) disable iff (sys_rst)
    state_reg == PWR_AWAKE ##1 state_reg == PWR_CYC_SLEEP);
  COV_LISTEN_SYNC: cover property (@(posedge mclk) disable iff (sys_rst)
    state_reg == PWR_LISTEN ##1 state_reg == PWR_SYNC ##[1:20] state_reg == PWR_AWAKE);
  COV_PIN_SLEEP: cover property (@(posedge mclk) disable iff (sys_rst)
    state_reg == PWR_PIN_SLEEP);

endmodule
`default_nettype wire

// ===== slpid_host.sv
`timescale 1ns/10ps
`default_nettype none
module slpid_host (
  input  wire logic                  mclk,
  output logic                       cmd_valid,
  output slpid_pkg::slpid_cmd_t      cmd,
  input  wire logic                  rsp_valid,
  input  wire slpid_pkg::slpid_rsp_t rsp
);
  import slpid_pkg::*;

  initial begin
    cmd_valid = 1'b0;
    cmd       = '0;
  end

  // One command per call; the answer is taken in the cycle after the taking edge.
  // A released command bus shows the inverse of the last value.
  task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] wd,
                      output slpid_rsp_t r, output logic got);
    @(negedge mclk);
    cmd_valid = 1'b1;
    cmd       = {wr, code, wd};
    @(negedge mclk);
    cmd_valid = 1'b0;
    cmd       = ~{wr, code, wd};
    got       = rsp_valid;
    r         = rsp;
  endtask
endmodule
`default_nettype wire

// ===== slpid_top_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module slpid_top_tb_top;
  import slpid_pkg::*;
  localparam int          TK = 4;
  // Arbitrary serial number.
  localparam logic [31:0] SN = 32'h5a3c_9e71;
  logic       mclk, sys_rst, cmd_valid, tx_active, rx_active;
  logic       preamble_detect, preamble_done, sleep_pin, rsp_valid;
  logic       module_asleep, rx_enable;
  slpid_cmd_t cmd;
  slpid_rsp_t rsp;
  int         n_errors = 0;
  int         checked = 0;
  int         cyc = 0;
  int         sel_m = 0;
  int         idle_m = 'h64;
  int         n, s, d;

  slpid_top #(.TICK_CYCLES(TK), .LISTEN_TICKS(16'h0001), .SERIAL_NUM(SN)) i_slpid_top (
    .mclk(mclk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd(cmd),
    .tx_active(tx_active), .rx_active(rx_active), .preamble_detect(preamble_detect),
    .preamble_done(preamble_done), .sleep_pin(sleep_pin), .rsp_valid(rsp_valid),
    .rsp(rsp), .module_asleep(module_asleep), .rx_enable(rx_enable));
  slpid_host i_slpid_host (
    .mclk(mclk), .cmd_valid(cmd_valid), .cmd(cmd), .rsp_valid(rsp_valid), .rsp(rsp));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      give_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input int got, input int lo, input int hi);
    checked++;
    if (got < lo || got > hi) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h to %h", $time, got, lo, hi);
    end
  endtask

  // Predicts the answer from the register model, then checks the strobe and its release.
  task automatic do_cmd(input logic wr, input logic [7:0] code, input logic [15:0] wd);
    slpid_rsp_t r;
    logic       got;
    logic       ok;
    int         nb;
    int         dat;
    ok  = 1'b1;
    nb  = 2;
    dat = 0;
    case (code)
      CMD_SLEEP_SELECT: begin
        nb = 1;
        if (wr && (wd == 2 || wd > 8)) ok = 1'b0;
        else if (wr) sel_m = wd;
        dat = sel_m;
      end
      CMD_IDLE_TIME: begin
        if (wr && wd < 16'h0010) ok = 1'b0;
        else if (wr) idle_m = wd;
        dat = idle_m;
      end
      CMD_SERIAL_UPPER: begin
        ok  = ~wr;
        dat = SN[31:16];
      end
      CMD_SERIAL_LOWER: begin
        ok  = ~wr;
        dat = SN[15:0];
      end
      default: begin
        ok = 1'b0;
        nb = 0;
      end
    endcase
    i_slpid_host.xfer(wr, code, wd, r, got);
    chk({31'h0, got}, 32'h1);
    chk({13'h0, r}, {13'h0, ok, nb[1:0], dat[15:0]});
    @(negedge mclk);
    chk({12'h0, rsp_valid, rsp}, 32'h0);
  endtask

  task automatic wait_for(input bit on_sl, input logic lvl, input int lim, output int cnt);
    cnt = 0;
    while ((on_sl ? module_asleep : rx_enable) !== lvl && cnt < lim) begin
      @(negedge mclk);
      cnt++;
    end
  endtask

  initial begin
    sys_rst = 1'b1;
    {tx_active, rx_active, preamble_detect, preamble_done, sleep_pin} = 5'h00;
    void'($urandom(52));
    repeat (3) @(negedge mclk);
    sys_rst = 1'b0;
    do_cmd(1'b0, 8'h01, 16'h0000);
    do_cmd(1'b0, 8'h02, 16'h0000);
    $display("reset values done");
    do_cmd(1'b0, 8'h25, 16'h0000);
    do_cmd(1'b0, 8'h26, 16'h0000);
    do_cmd(1'b1, 8'h25, 16'($urandom));
    do_cmd(1'b1, 8'h26, 16'($urandom));
    do_cmd(1'b0, 8'h25, 16'h0000);
    do_cmd(1'b0, 8'h26, 16'h0000);
    do_cmd(1'b0, 8'h77, 16'h0000);
    $display("serial number done");
    for (int v = 0; v < 10; v++) do_cmd(1'b1, 8'h01, 16'(v));
    do_cmd(1'b1, 8'h01, 16'h0103);
    do_cmd(1'b1, 8'h02, 16'h000f);
    do_cmd(1'b1, 8'h02, 16'hffff);
    do_cmd(1'b1, 8'h02, 16'($urandom_range(16'h0010, 16'hffff)));
    do_cmd(1'b1, 8'h02, 16'h0010);
    $display("register access done");
    do_cmd(1'b1, 8'h01, 16'h0000);
    repeat (100) @(negedge mclk);
    chk({30'h0, module_asleep, rx_enable}, 32'h1);
    do_cmd(1'b1, 8'h01, 16'h0001);
    repeat (100) @(negedge mclk);
    chk({30'h0, module_asleep, rx_enable}, 32'h1);
    sleep_pin = 1'b1;
    wait_for(1'b1, 1'b1, 8, n);
    chk_rng(n, 2, 5);
    sleep_pin = 1'b0;
    wait_for(1'b1, 1'b0, 8, n);
    chk_rng(n, 2, 5);
    $display("no sleep and pin sleep done");
    for (s = 3; s <= 8; s++) begin
      do_cmd(1'b1, 8'h02, 16'h0010);
      do_cmd(1'b1, 8'h01, 16'(s));
      repeat ($urandom_range(10, 50)) @(negedge mclk);
      chk({31'h0, module_asleep}, 32'h0);
      if (s[0]) tx_active = 1'b1;
      else rx_active = 1'b1;
      @(negedge mclk);
      {tx_active, rx_active} = 2'h0;
      wait_for(1'b1, 1'b1, 100, n);
      chk_rng(n, 16 * TK - 4, 16 * TK + 3);
      d = (5 << (s - 3)) * TK;
      wait_for(1'b1, 1'b0, d + 10, n);
      chk_rng(n, d - 1, d + 2);
      chk({31'h0, rx_enable}, 32'h0);
      if (s == 3) begin
        wait_for(1'b1, 1'b1, 10, n);
        chk_rng(n, TK - 2, TK + 3);
        wait_for(1'b1, 1'b0, d + 10, n);
        chk_rng(n, d - 1, d + 2);
      end
      preamble_detect = 1'b1;
      @(negedge mclk);
      preamble_detect = 1'b0;
      repeat (2 * TK) @(negedge mclk);
      chk({30'h0, module_asleep, rx_enable}, 32'h0);
      preamble_done = 1'b1;
      @(negedge mclk);
      preamble_done = 1'b0;
      wait_for(1'b0, 1'b1, 4, n);
      chk_rng(n, 0, 2);
      $display("cyclic setting %0d done", s);
    end
    // Reset in mid-run with a cyclic selector and a changed idle time.
    do_cmd(1'b1, 8'h02, 16'h0020);
    sys_rst = 1'b1;
    repeat (3) @(negedge mclk);
    sys_rst = 1'b0;
    sel_m   = 0;
    idle_m  = 'h64;
    chk({30'h0, module_asleep, rx_enable}, 32'h1);
    do_cmd(1'b0, 8'h01, 16'h0000);
    do_cmd(1'b0, 8'h02, 16'h0000);
    $display("mid-run reset done");
    do_cmd(1'b1, 8'h01, 16'h0000);
    chk({30'h0, module_asleep, rx_enable}, 32'h1);
    give_verdict();
  end
endmodule
`default_nettype wire
